// file: hdl/trg_ctrl.sv
// Trigger input and output control with Wishbone registers and interrupt
// Behaviour
// - Input enabled and output disabled: measure only after an external trigger edge.
// - Output enabled and input disabled: drive a trigger impulse to the second sensor.
// - Both enabled together: neither works, a warning is raised.
// - Input edge code: 0 rising, 1 falling, 2 every edge.
// - Input mode waits the programmed 0 to 60000 ms before measuring.
// - Output edge code uses the same encoding and shapes the driven impulse.
// - Output delay 0 to 60000 ms; a zero delay disables the output.
// - Each input trigger edge taken while idle starts one single distance measurement when its delay ends, none if input mode ends first.
module trg_ctrl #(
  parameter int unsigned TICK_CYCLES = trg_pkg::TICK_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic trig_i,
  output logic trig_o,
  output logic trig_oe,
  input wire logic meas_began,
  output logic single_distance_measurement,
  output logic irq
);

  typedef enum logic [1:0] {S_IDLE, S_WAIT_IN, S_WAIT_OUT, S_PULSE} trg_state_t;

  trg_pkg::trg_cfg_t in_cfg_r;
  trg_pkg::trg_cfg_t output_trigger_config_r;
  logic [trg_pkg::IRQ_W-1:0] irq_stat_r;
  logic [trg_pkg::IRQ_W-1:0] irq_mask_r;
  logic [trg_pkg::IRQ_W-1:0] irq_set;
  logic sync0_r;
  logic sync1_r;
  logic line_prev_r;
  logic any_lvl_r;
  logic conflict;
  logic conflict_prev_r;
  logic in_act;
  logic out_act;
  logic hit;
  logic [15:0] in_delay;
  logic [15:0] out_delay;
  logic tmr_done;
  logic tmr_busy;
  logic wr;
  logic rd_cyc;
  logic [31:0] rd_data;
  logic [31:0] status;
  trg_pkg::trg_tmr_req_t tmr_req;
  trg_state_t state_r;
  trg_state_t state_nxt;

  // Byte lanes to bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  // Qualifying edge for an edge code
  function automatic logic edge_match(input logic [1:0] code, input logic prev,
                                      input logic cur);
    unique case (code)
      trg_pkg::EDGE_RISE: edge_match = !prev && cur;
      trg_pkg::EDGE_FALL: edge_match = prev && !cur;
      trg_pkg::EDGE_ANY: edge_match = prev != cur;
      default: edge_match = 1'b0;
    endcase
  endfunction : edge_match

  // Delays above the documented range are held at the maximum
  function automatic logic [15:0] clamp_ms(input logic [15:0] v);
    clamp_ms = (v > trg_pkg::DELAY_MAX_MS) ? trg_pkg::DELAY_MAX_MS : v;
  endfunction : clamp_ms

  assign in_delay = clamp_ms(in_cfg_r.delay_ms);
  assign out_delay = clamp_ms(output_trigger_config_r.delay_ms);
  assign conflict = in_cfg_r.enable && output_trigger_config_r.enable;
  assign in_act = in_cfg_r.enable && !conflict;
  assign out_act = output_trigger_config_r.enable && !conflict && (out_delay != 16'h0000);
  assign hit = edge_match(in_cfg_r.edge_sel, line_prev_r, sync1_r);
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd_cyc = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Trigger pin synchroniser; first stage feeds only the second
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync0_r <= 1'b0;
      sync1_r <= 1'b0;
      line_prev_r <= 1'b0;
    end else if (ce) begin
      sync0_r <= trig_i;
      sync1_r <= sync0_r;
      line_prev_r <= sync1_r;
    end
  end

  // Sequencer
  always_comb begin
    state_nxt = state_r;
    tmr_req = '0;
    unique case (state_r)
      S_IDLE: begin
        if (in_act && hit) begin
          tmr_req.start = 1'b1;
          tmr_req.delay_ms = in_delay;
          state_nxt = S_WAIT_IN;
        end else if (out_act && meas_began) begin
          tmr_req.start = 1'b1;
          tmr_req.delay_ms = out_delay;
          state_nxt = S_WAIT_OUT;
        end
      end
      S_WAIT_IN: begin
        if (!in_act) begin
          tmr_req.abort = 1'b1;
          state_nxt = S_IDLE;
        end else if (tmr_done) begin
          state_nxt = S_IDLE;
        end
      end
      S_WAIT_OUT: begin
        if (!out_act) begin
          tmr_req.abort = 1'b1;
          state_nxt = S_IDLE;
        end else if (tmr_done) begin
          tmr_req.start = 1'b1;
          tmr_req.delay_ms = trg_pkg::PULSE_MS;
          state_nxt = S_PULSE;
        end
      end
      S_PULSE: begin
        if (!out_act) begin
          tmr_req.abort = 1'b1;
          state_nxt = S_IDLE;
        end else if (tmr_done) begin
          state_nxt = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r <= S_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  trg_delay_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clock(clock),
    .sys_rst(sys_rst),
    .ce(ce),
    .req(tmr_req),
    .done(tmr_done),
    .busy(tmr_busy)
  );

  // One measurement per accepted input trigger
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      single_distance_measurement <= 1'b0;
    end else if (ce) begin
      single_distance_measurement <= (state_r == S_WAIT_IN) && in_act && tmr_done;
    end
  end

  // Driven trigger line: rising idles low, falling idles high, every edge toggles
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      any_lvl_r <= 1'b0;
      trig_o <= 1'b0;
      trig_oe <= 1'b0;
    end else if (ce) begin
      trig_oe <= out_act;
      if (state_r == S_WAIT_OUT && state_nxt == S_PULSE) begin
        any_lvl_r <= !any_lvl_r;
      end
      unique case (output_trigger_config_r.edge_sel)
        trg_pkg::EDGE_RISE: trig_o <= out_act && (state_nxt == S_PULSE);
        trg_pkg::EDGE_FALL: trig_o <= !(out_act && (state_nxt == S_PULSE));
        trg_pkg::EDGE_ANY: trig_o <= out_act &&
          (any_lvl_r ^ (state_r == S_WAIT_OUT && state_nxt == S_PULSE));
        default: trig_o <= 1'b0;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      in_cfg_r <= trg_pkg::CFG_RST;
      output_trigger_config_r <= trg_pkg::CFG_RST;
    end else if (ce && wr) begin
      if (wb_adr_i == trg_pkg::ADDR_IN_CFG) begin
        in_cfg_r <= (in_cfg_r & ~lane_mask(wb_sel_i)) | (wb_dat_i & lane_mask(wb_sel_i));
      end
      if (wb_adr_i == trg_pkg::ADDR_OUT_CFG) begin
        output_trigger_config_r <= (output_trigger_config_r & ~lane_mask(wb_sel_i)) |
                                   (wb_dat_i & lane_mask(wb_sel_i));
      end
    end
  end

  // Interrupt status: set wins over a write-one clear
  assign irq_set[trg_pkg::IRQ_MEAS] = (state_r == S_WAIT_IN) && in_act && tmr_done;
  assign irq_set[trg_pkg::IRQ_PULSE] = (state_r == S_WAIT_OUT) && out_act && tmr_done;
  assign irq_set[trg_pkg::IRQ_WARN] = conflict && !conflict_prev_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      conflict_prev_r <= 1'b0;
      irq_stat_r <= trg_pkg::IRQ_RST;
      irq_mask_r <= trg_pkg::IRQ_RST;
      irq <= 1'b0;
    end else if (ce) begin
      conflict_prev_r <= conflict;
      irq <= |(irq_stat_r & irq_mask_r);
      if (wr && wb_adr_i == trg_pkg::ADDR_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r &
                       ~(wb_dat_i[trg_pkg::IRQ_W-1:0] & {trg_pkg::IRQ_W{wb_sel_i[0]}})) |
                      irq_set;
      end else begin
        irq_stat_r <= irq_stat_r | irq_set;
      end
      if (wr && wb_adr_i == trg_pkg::ADDR_IRQ_MASK && wb_sel_i[0]) begin
        irq_mask_r <= wb_dat_i[trg_pkg::IRQ_W-1:0];
      end
    end
  end

  // Bus read path and acknowledge
  always_comb begin
    status = 32'h0000_0000;
    status[trg_pkg::ST_IN_ACT] = in_act;
    status[trg_pkg::ST_OUT_ACT] = out_act;
    status[trg_pkg::ST_CONFLICT] = conflict;
    status[trg_pkg::ST_BUSY] = tmr_busy || (state_r != S_IDLE);
    status[trg_pkg::ST_LINE] = sync1_r;
    status[trg_pkg::ST_DRIVE] = trig_o;
    unique case (wb_adr_i)
      trg_pkg::ADDR_IN_CFG: rd_data = in_cfg_r;
      trg_pkg::ADDR_OUT_CFG: rd_data = output_trigger_config_r;
      trg_pkg::ADDR_STATUS: rd_data = status;
      trg_pkg::ADDR_IRQ_STAT: rd_data = {29'h0000_0000, irq_stat_r};
      trg_pkg::ADDR_IRQ_MASK: rd_data = {29'h0000_0000, irq_mask_r};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= rd_cyc;
      wb_dat_o <= rd_cyc ? rd_data : 32'h0000_0000;
    end
  end

  sequence seq_edge_taken;
    ce && state_r == S_IDLE && in_act && hit;
  endsequence

  sequence seq_wait_done;
    ce && state_r == S_WAIT_IN && in_act && tmr_done;
  endsequence

  chk_meas_input: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(single_distance_measurement) |-> $past(in_act))
    else $error("Measurement started outside input mode");

  chk_drive_mode: assert property (@(posedge clock) disable iff (sys_rst)
    (ce && out_act) |=> trig_oe) else $error("Output mode not driving line");

  chk_conflict_quiet: assert property (@(posedge clock) disable iff (sys_rst)
    (ce && conflict) |=> !trig_oe && !single_distance_measurement)
    else $error("Conflict but trigger still active");

  chk_edge_start: assert property (@(posedge clock) disable iff (sys_rst)
    seq_edge_taken |=> state_r == S_WAIT_IN) else $error("Edge not taken");

  chk_in_delay: assert property (@(posedge clock) disable iff (sys_rst)
    seq_edge_taken ##1 (state_r == S_WAIT_IN && ce && in_act)[*1] ##0 seq_wait_done
      |=> single_distance_measurement) else $error("Measurement not issued");

  chk_pulse_level: assert property (@(posedge clock) disable iff (sys_rst)
    (ce && state_r == S_PULSE && out_act &&
     output_trigger_config_r.edge_sel == trg_pkg::EDGE_RISE) |-> trig_o)
    else $error("Rising impulse not high");

  chk_zero_off: assert property (@(posedge clock) disable iff (sys_rst)
    (ce && output_trigger_config_r.delay_ms == 16'h0000) |=> !trig_oe)
    else $error("Zero delay output still on");

  chk_single_meas: assert property (@(posedge clock) disable iff (sys_rst)
    single_distance_measurement |=> !single_distance_measurement)
    else $error("Measurement start longer than one cycle");

  chk_sync_stage: assert property (@(posedge clock) disable iff (sys_rst)
    (ce && $past(ce)) |-> sync1_r == $past(sync0_r))
    else $error("Synchroniser stage skipped");

  chk_wb_ack: assert property (@(posedge clock) disable iff (sys_rst)
    (ce && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o || !ce)
    else $error("Bus acknowledge not a single cycle");

  chk_ce_freeze: assert property (@(posedge clock) disable iff (sys_rst)
    !ce |=> state_r == $past(state_r) && wb_ack_o == $past(wb_ack_o))
    else $error("State moved while clock enable low");

endmodule : trg_ctrl

// file: hdl/trg_delay_timer.sv
// Millisecond tick generator and delay counter for trigger timing
module trg_delay_timer #(
  parameter int unsigned TICK_CYCLES = trg_pkg::TICK_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire trg_pkg::trg_tmr_req_t req,
  output logic done,
  output logic busy
);

  localparam logic [trg_pkg::PRE_W-1:0] PRE_LAST = trg_pkg::PRE_W'(TICK_CYCLES - 1);

  logic [trg_pkg::PRE_W-1:0] pre_r;
  logic tick;
  logic [15:0] cnt_r;
  logic [15:0] goal_r;

  assign tick = (pre_r == PRE_LAST);

  // Prescaler restarts with each delay so the first millisecond is whole
  always_ff @(posedge clock) begin
    if (sys_rst || (ce && (req.start || tick))) begin
      pre_r <= '0;
    end else if (ce) begin
      pre_r <= pre_r + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt_r <= 16'h0000;
      goal_r <= 16'h0000;
    end else if (ce) begin
      done <= 1'b0;
      if (req.abort) begin
        busy <= 1'b0;
      end else if (req.start) begin
        cnt_r <= 16'h0000;
        goal_r <= req.delay_ms;
        busy <= (req.delay_ms != 16'h0000);
        done <= (req.delay_ms == 16'h0000);
      end else if (busy && tick) begin
        cnt_r <= cnt_r + 16'h0001;
        if (cnt_r + 16'h0001 == goal_r) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  chk_done_on_tick: assert property (@(posedge clock) disable iff (sys_rst)
    (ce && busy && !req.abort && !req.start && tick && cnt_r + 16'h0001 == goal_r)
      |=> done && !busy) else $error("Delay end missed its tick");

  chk_zero_delay: assert property (@(posedge clock) disable iff (sys_rst)
    (ce && req.start && !req.abort && req.delay_ms == 16'h0000) |=> done)
    else $error("Zero delay did not finish at once");

endmodule : trg_delay_timer

// file: pkg/trg_pkg.sv
// Constants and types shared by the trigger block and its delay timer
package trg_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_IN_CFG = 8'h00;
  localparam logic [7:0] ADDR_OUT_CFG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  // Reset values
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // Edge codes of both configurations
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_ANY = 2'h2;

  // Status bit positions
  localparam int ST_IN_ACT = 0;
  localparam int ST_OUT_ACT = 1;
  localparam int ST_CONFLICT = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_LINE = 4;
  localparam int ST_DRIVE = 5;

  // Interrupt bit positions
  localparam int IRQ_MEAS = 0;
  localparam int IRQ_PULSE = 1;
  localparam int IRQ_WARN = 2;
  localparam int IRQ_W = 3;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TICK_NS = 1000000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int PRE_W = 18;
  localparam logic [15:0] DELAY_MAX_MS = 16'hEA60;
  localparam logic [15:0] PULSE_MS = 16'h0001;

  // One trigger configuration word
  typedef struct packed {
    logic [15:0] delay_ms;
    logic [12:0] rsvd;
    logic [1:0] edge_sel;
    logic enable;
  } trg_cfg_t;

  // Request to the delay timer
  typedef struct packed {
    logic start;
    logic abort;
    logic [15:0] delay_ms;
  } trg_tmr_req_t;

endpackage : trg_pkg

// file: tb/tb_top.sv
// Self-checking bench for the trigger control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TK = 10;
  localparam int CHG[3] = '{2, 2, 1};
  typedef struct {int lo; int hi;} trg_win_t;
  logic clock, sys_rst, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic trig_o, trig_oe, meas_began, sdm, irq, src_line, pin;
  int chg_cnt, dly;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 43897;
  trg_win_t notes[$];
  trg_win_t w;
  // Pin level seen by everyone: block drives while enabled, source otherwise
  assign pin = trig_oe ? trig_o : src_line;

  trg_ctrl #(.TICK_CYCLES(TK)) trg_ctrl_i (
    .clock(clock), .sys_rst(sys_rst), .ce(ce), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trig_i(pin),
    .trig_o(trig_o), .trig_oe(trig_oe), .meas_began(meas_began),
    .single_distance_measurement(sdm), .irq(irq)
  );
  trg_far_model trg_far_model_i (
    .clock(clock), .trig_o(trig_o), .trig_oe(trig_oe), .src_line(src_line),
    .chg_cnt(chg_cnt)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic waitc(input int n);
    repeat (n) @(posedge clock);
  endtask : waitc

  // Classic single cycle; waits for ack under a bounded count
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n >= 50) chk("wb_ack", 32'h0, 32'h1);
  endtask : wb

  task automatic rdc(input logic [7:0] adr, input logic [31:0] msk, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    chk($sformatf("reg_%0h", adr), rd & msk, exp);
  endtask : rdc

  task automatic meas_pulse();
    trg_far_model_i.clr_cnt();
    @(posedge clock) meas_began <= 1'b1;
    @(posedge clock) meas_began <= 1'b0;
  endtask : meas_pulse

  // Takes the oldest expected start window whenever a start pulse shows
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (sys_rst === 1'b0 && sdm === 1'b1) begin
      if (notes.size() == 0) chk("unexpected_start", 32'h1, 32'h0);
      else begin
        w = notes.pop_front();
        chk("start_time", 32'(cyc >= w.lo && cyc <= w.hi), 32'h1);
      end
    end
  end

  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end

  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    meas_began = 1'b0;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    rdc(trg_pkg::ADDR_IN_CFG, 32'hFFFFFFFF, trg_pkg::CFG_RST);
    rdc(trg_pkg::ADDR_OUT_CFG, 32'hFFFFFFFF, trg_pkg::CFG_RST);
    rdc(trg_pkg::ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
    rdc(trg_pkg::ADDR_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
    rdc(8'h14, 32'hFFFFFFFF, 32'h0);
    // Input mode for each edge code with a random short delay
    for (int code = 0; code < 3; code++) begin
      dly = $random(seed) & 3;
      wb(1'b1, trg_pkg::ADDR_IN_CFG, {dly[15:0], 13'h0, code[1:0], 1'b1});
      for (int v = 1; v >= 0; v--) begin
        trg_far_model_i.set_line(v[0]);
        if (code == 2 || code == 1 - v) notes.push_back('{cyc + dly * TK, cyc + dly * TK + 10});
        waitc(dly * TK + 20);
      end
    end
    chk("notes_left", notes.size(), 32'h0);
    rdc(trg_pkg::ADDR_IRQ_STAT, 32'hFFFFFFFF, 32'h1);
    // Output mode for each edge code
    wb(1'b1, trg_pkg::ADDR_IN_CFG, 32'h0);
    for (int code = 0; code < 3; code++) begin
      wb(1'b1, trg_pkg::ADDR_OUT_CFG, {16'h0002, 13'h0, code[1:0], 1'b1});
      waitc(5);
      meas_pulse();
      waitc(3 * TK + 20);
      chk("impulse_changes", chg_cnt, CHG[code]);
      chk("trig_oe_out", trig_oe, 32'h1);
    end
    wb(1'b1, trg_pkg::ADDR_IRQ_MASK, 32'h2);
    waitc(3);
    chk("irq_set", irq, 32'h1);
    wb(1'b1, trg_pkg::ADDR_IRQ_STAT, 32'h2);
    waitc(3);
    chk("irq_clr", irq, 32'h0);
    rdc(trg_pkg::ADDR_IRQ_STAT, 32'hFFFFFFFF, 32'h1);
    // Zero output delay leaves the output function off
    wb(1'b1, trg_pkg::ADDR_OUT_CFG, 32'h0000_0001);
    waitc(3);
    chk("trig_oe_zero", trig_oe, 32'h0);
    meas_pulse();
    waitc(40);
    chk("zero_delay_changes", chg_cnt, 32'h0);
    // Edge code 3 selects no edge: line changes start nothing
    wb(1'b1, trg_pkg::ADDR_OUT_CFG, 32'h0);
    wb(1'b1, trg_pkg::ADDR_IN_CFG, 32'h0000_0007);
    trg_far_model_i.set_line(1'b1);
    waitc(10);
    trg_far_model_i.set_line(1'b0);
    waitc(10);
    // Clock enable low for 20 cycles mid-delay pushes the start back by 20
    wb(1'b1, trg_pkg::ADDR_IN_CFG, 32'h0001_0001);
    trg_far_model_i.set_line(1'b1);
    notes.push_back('{cyc + TK + 20, cyc + TK + 30});
    waitc(5);
    ce <= 1'b0;
    waitc(20);
    ce <= 1'b1;
    waitc(TK + 20);
    trg_far_model_i.set_line(1'b0);
    waitc(10);
    // Both modes enabled: warning, no start, no drive
    wb(1'b1, trg_pkg::ADDR_OUT_CFG, 32'h0002_0001);
    wb(1'b1, trg_pkg::ADDR_IN_CFG, 32'h0000_0001);
    waitc(3);
    rdc(trg_pkg::ADDR_STATUS, 32'h7, 32'h4);
    trg_far_model_i.set_line(1'b1);
    waitc(30);
    trg_far_model_i.set_line(1'b0);
    waitc(30);
    chk("trig_oe_conflict", trig_oe, 32'h0);
    rdc(trg_pkg::ADDR_IRQ_STAT, 32'h4, 32'h4);
    wb(1'b1, trg_pkg::ADDR_IRQ_MASK, 32'h4);
    waitc(3);
    chk("irq_warn", irq, 32'h1);
    chk("notes_left_end", notes.size(), 32'h0);
    end_sim();
  end
endmodule : tb_top

// file: tb/trg_far_model.sv
// Far side model: external trigger source and receiving second sensor
module trg_far_model (
  input wire logic clock,
  input wire logic trig_o,
  input wire logic trig_oe,
  output logic src_line,
  output int chg_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_r;
  initial begin
    src_line = 1'b0;
    chg_cnt = 0;
    last_r = 1'b0;
  end
  // Receiving sensor counts every level change of the driven impulse
  always @(posedge clock) begin
    if (trig_oe === 1'b1 && trig_o !== last_r) chg_cnt <= chg_cnt + 1;
    last_r <= trig_o;
  end
  task automatic set_line(input logic v);
    @(posedge clock);
    src_line <= v;
  endtask : set_line
  task automatic clr_cnt();
    @(posedge clock);
    chg_cnt <= 0;
  endtask : clr_cnt
endmodule : trg_far_model
